// [rtl/dept_tracker.sv]
// top of the event pending tracker: axi4-lite slave, enable mask, pending flags
// assumes trigger inputs come from logic on REF_CLK; completion pulses from the queue side
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

// Summary of operation
// R1: high set port bit n enables event n+32
// R2: high set port write-only, only sets
// R3: queued trigger sets channel pending flag
// R4: pending channel gets no further prioritization
// R5: flag cleared by hardware or software first
// R6: pending flags cover channels 0 to 63
// R7: pending words read-only, writes ignored
// R8: low clear port one clears flag n
// R9: low clear port zero bits ignored
// R10: low clear port write-only, reads zero
// R11: enable mask changes only via ports
// R12: enabled bit lets latched event arbitrate
// R13: high clear port one clears flag n+32
// R14: hardware set beats same-cycle clear
module dept_tracker (
  input  wire logic        REF_CLK,           // 40 MHz clock
  input  wire logic        RESET,             // synchronous reset, active high
  input  wire logic [7:0]  S_AWADDR,          // write address
  input  wire logic        S_AWVALID,         // write address valid
  output logic             S_AWREADY,         // write address ready
  input  wire logic [31:0] S_WDATA,           // write data
  input  wire logic [3:0]  S_WSTRB,           // write strobes
  input  wire logic        S_WVALID,          // write data valid
  output logic             S_WREADY,          // write data ready
  output logic [1:0]       S_BRESP,           // write response
  output logic             S_BVALID,          // write response valid
  input  wire logic        S_BREADY,          // write response ready
  input  wire logic [7:0]  S_ARADDR,          // read address
  input  wire logic        S_ARVALID,         // read address valid
  output logic             S_ARREADY,         // read address ready
  output logic [31:0]      S_RDATA,           // read data
  output logic [1:0]       S_RRESP,           // read response
  output logic             S_RVALID,          // read response valid
  input  wire logic        S_RREADY,          // read response ready
  input  wire logic [63:0] MANUAL_SET_FLAGS,  // manual trigger levels per channel
  input  wire logic [63:0] LATCHED_EVENT_FLAGS, // latched external events per channel
  input  wire logic [63:0] CHAIN_FLAGS,       // chain trigger levels per channel
  input  wire logic [63:0] HW_DONE,           // hardware clear of a pending flag
  output logic             XFER_REQUEST,      // a channel was queued this cycle
  output logic [5:0]       XFER_CHANNEL,      // which channel was queued
  output logic [63:0]      QUEUED_FLAGS       // pending flags, all channels
);

  // ****************************************************************
  // write channel state
  // ****************************************************************
  logic              aw_have_q;               // write address captured
  logic [7:0]        aw_addr_q;               // captured write address
  logic              w_have_q;                // write data captured
  dept_pkg::dept_wdata_t w_q;                 // captured write word
  logic              bvalid_q;                // response pending
  logic [1:0]        bresp_q;                 // response code
  logic              wr_go;                   // both halves present, do the write
  logic [31:0]       wr_word;                 // write word masked by strobes
  logic              wr_mapped;               // address decodes
  logic              aw_rdy_q, w_rdy_q, ar_rdy_q; // ready flops

  // ****************************************************************
  // read channel state
  // ****************************************************************
  logic              rvalid_q;                // read data pending
  logic [31:0]       rdata_q;                 // read data
  logic [1:0]        rresp_q;                 // read response
  logic [31:0]       rd_word;                 // decoded read word
  logic              rd_mapped;               // read address decodes

  // ****************************************************************
  // block state
  // ****************************************************************
  logic [63:0]       enable_mask;             // event_enable_mask_low/high
  logic [63:0]       queued_flags;            // queued_flags_low/high
  dept_pkg::dept_setclr_t en_req;             // enable set/clear requests
  dept_pkg::dept_setclr_t q_req;              // pending set/clear requests
  logic [63:0]       cand;                    // channels allowed to arbitrate
  logic [63:0]       grant_hot;               // channel granted this cycle
  logic              grant_vld;               // registered grant valid
  logic [5:0]        grant_idx;               // registered grant index
  logic [63:0]       queued_q;                // output copy of flags

  // ****************************************************************
  // axi write address / data capture
  // ****************************************************************
  // address and data are accepted independently, in either order
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (S_AWVALID && S_AWREADY) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= S_AWADDR;
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      w_have_q <= 1'b0;
      w_q      <= '0;
    end else if (S_WVALID && S_WREADY) begin
      w_have_q <= 1'b1;
      w_q      <= '{data: S_WDATA, strb: S_WSTRB};
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end
  end

  // ready flops: low in and just after reset, and while a slot is full
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      aw_rdy_q <= 1'b0;
      w_rdy_q  <= 1'b0;
      ar_rdy_q <= 1'b0;
    end else begin
      aw_rdy_q <= aw_have_q ? wr_go : !(S_AWVALID && aw_rdy_q);
      w_rdy_q  <= w_have_q ? wr_go : !(S_WVALID && w_rdy_q);
      ar_rdy_q <= rvalid_q ? S_RREADY : !(S_ARVALID && ar_rdy_q);
    end
  end
  assign S_AWREADY = aw_rdy_q;
  assign S_WREADY  = w_rdy_q;

  // a write is performed once both halves are held and no response is waiting
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;

  // strobes mask the word; unwritten lanes act as zero, i.e. no effect
  always_comb begin
    wr_word = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      wr_word[b*8 +: 8] = w_q.strb[b] ? w_q.data[b*8 +: 8] : 8'h00;
    end
  end

  // decode of writable and read-only addresses; read-only writes are okay but ignored
  always_comb begin
    case (aw_addr_q & 8'hFC)
      dept_pkg::OFF_ENABLE_SET_HIGH,
      dept_pkg::OFF_ENABLE_SET_LOW,
      dept_pkg::OFF_ENABLE_CLR_HIGH,
      dept_pkg::OFF_ENABLE_CLR_LOW,
      dept_pkg::OFF_ENABLE_MASK_LOW,
      dept_pkg::OFF_ENABLE_MASK_HIGH,
      dept_pkg::OFF_QUEUED_LOW,
      dept_pkg::OFF_QUEUED_HIGH,
      dept_pkg::OFF_QUEUED_CLR_LOW,
      dept_pkg::OFF_QUEUED_CLR_HIGH: wr_mapped = 1'b1;
      default:                       wr_mapped = 1'b0;
    endcase
  end

  // write response, raised on the same edge at which the write takes effect
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      bvalid_q <= 1'b0;
      bresp_q  <= dept_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_mapped ? dept_pkg::RESP_OKAY : dept_pkg::RESP_SLVERR;
    end else if (S_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end
  assign S_BVALID = bvalid_q;
  assign S_BRESP  = bresp_q;

  // ****************************************************************
  // port writes turned into set and clear requests
  // ****************************************************************
  // the mask words themselves have no write path at all
  always_comb begin
    en_req = '0;
    if (wr_go) begin
      case (aw_addr_q & 8'hFC)
        dept_pkg::OFF_ENABLE_SET_HIGH: en_req.set[63:32] = wr_word;  // [R1] [R2] [R11]
        dept_pkg::OFF_ENABLE_SET_LOW:  en_req.set[31:0]  = wr_word;  // [R11]
        dept_pkg::OFF_ENABLE_CLR_HIGH: en_req.clr[63:32] = wr_word;  // [R11]
        dept_pkg::OFF_ENABLE_CLR_LOW:  en_req.clr[31:0]  = wr_word;  // [R11]
        default:                       en_req = '0;
      endcase
    end
  end

  // pending flags: set by queued grants, cleared by software ports or hardware
  always_comb begin
    q_req     = '0;
    q_req.set = grant_hot;                                         // [R3]
    q_req.clr = HW_DONE;                                           // [R5]
    if (wr_go) begin
      case (aw_addr_q & 8'hFC)
        dept_pkg::OFF_QUEUED_CLR_LOW:  q_req.clr[31:0]  = HW_DONE[31:0] | wr_word;   // [R8] [R9]
        dept_pkg::OFF_QUEUED_CLR_HIGH: q_req.clr[63:32] = HW_DONE[63:32] | wr_word;  // [R13]
        default:                       q_req.clr = HW_DONE;        // [R7] status writes change nothing
      endcase
    end
  end

  // ****************************************************************
  // flag words and arbitration
  // ****************************************************************
  dept_flagword #(.WIDTH(64)) u_enable (
    .clk     (REF_CLK),
    .rst     (RESET),
    .req     (en_req),
    .flags_q (enable_mask)
  );

  dept_flagword #(.WIDTH(64)) u_queued (
    .clk     (REF_CLK),
    .rst     (RESET),
    .req     (q_req),
    .flags_q (queued_flags)
  );

  // latched events count only when enabled; a pending channel never competes
  assign cand = ((LATCHED_EVENT_FLAGS & enable_mask) | MANUAL_SET_FLAGS | CHAIN_FLAGS)  // [R12]
                & ~queued_flags;                                                        // [R4] [R5]

  dept_arbiter #(.WIDTH(64)) u_arb (
    .clk         (REF_CLK),
    .rst         (RESET),
    .cand        (cand),
    .grant_vld_q (grant_vld),
    .grant_idx_q (grant_idx),
    .grant_hot   (grant_hot)
  );

  // ****************************************************************
  // axi read channel
  // ****************************************************************
  // write-only ports read as zero, they keep no state of their own
  always_comb begin
    rd_mapped = 1'b1;
    case (S_ARADDR & 8'hFC)
      dept_pkg::OFF_ENABLE_MASK_LOW:  rd_word = enable_mask[31:0];
      dept_pkg::OFF_ENABLE_MASK_HIGH: rd_word = enable_mask[63:32];
      dept_pkg::OFF_QUEUED_LOW:       rd_word = queued_flags[31:0];    // [R6]
      dept_pkg::OFF_QUEUED_HIGH:      rd_word = queued_flags[63:32];   // [R6]
      dept_pkg::OFF_ENABLE_SET_HIGH,
      dept_pkg::OFF_ENABLE_SET_LOW,
      dept_pkg::OFF_ENABLE_CLR_HIGH,
      dept_pkg::OFF_ENABLE_CLR_LOW,
      dept_pkg::OFF_QUEUED_CLR_LOW,
      dept_pkg::OFF_QUEUED_CLR_HIGH:  rd_word = dept_pkg::WORD_RESET;  // [R2] [R10]
      default: begin
        rd_word   = dept_pkg::WORD_RESET;
        rd_mapped = 1'b0;
      end
    endcase
  end

  // one read at a time; arready is high while no data waits
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rvalid_q <= 1'b0;
      rdata_q  <= dept_pkg::WORD_RESET;
      rresp_q  <= dept_pkg::RESP_OKAY;
    end else if (S_ARVALID && S_ARREADY) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_mapped ? dept_pkg::RESP_OKAY : dept_pkg::RESP_SLVERR;
    end else if (S_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end
  assign S_ARREADY = ar_rdy_q;
  assign S_RVALID  = rvalid_q;
  assign S_RDATA   = rdata_q;
  assign S_RRESP   = rresp_q;

  // ****************************************************************
  // queue-side outputs
  // ****************************************************************
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      queued_q <= dept_pkg::FLAGS_RESET;
    end else begin
      queued_q <= queued_flags;
    end
  end
  assign QUEUED_FLAGS = queued_q;
  assign XFER_REQUEST = grant_vld;
  assign XFER_CHANNEL = grant_idx;

endmodule // dept_tracker

// [rtl/dept_pkg.sv]
// package for the event pending tracker: register map, field layouts, bus types
// assumes an axi4-lite register slave with 32-bit data and word-aligned offsets
package dept_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_ENABLE_SET_HIGH   = 8'h00;   // write-only, sets enables 32-63
  localparam logic [7:0] OFF_ENABLE_SET_LOW    = 8'h04;   // write-only, sets enables 0-31
  localparam logic [7:0] OFF_ENABLE_CLR_HIGH   = 8'h08;   // write-only, clears enables 32-63
  localparam logic [7:0] OFF_ENABLE_CLR_LOW    = 8'h0C;   // write-only, clears enables 0-31
  localparam logic [7:0] OFF_ENABLE_MASK_LOW   = 8'h10;   // read-only enable mask 0-31
  localparam logic [7:0] OFF_ENABLE_MASK_HIGH  = 8'h14;   // read-only enable mask 32-63
  localparam logic [7:0] OFF_QUEUED_LOW        = 8'h18;   // read-only pending flags 0-31
  localparam logic [7:0] OFF_QUEUED_HIGH       = 8'h1C;   // read-only pending flags 32-63
  localparam logic [7:0] OFF_QUEUED_CLR_LOW    = 8'h20;   // write-only, clears pending 0-31
  localparam logic [7:0] OFF_QUEUED_CLR_HIGH   = 8'h24;   // write-only, clears pending 32-63

  // ****************************************************************
  // widths, reset values, responses
  // ****************************************************************
  localparam int          ADDR_W        = 8;              // register address width
  localparam int          CHANNELS      = 64;             // channels covered by the flags
  localparam logic [31:0] WORD_RESET    = 32'h0000_0000;  // every register resets to zero
  localparam logic [63:0] FLAGS_RESET   = 64'h0;          // all flags cleared at reset
  localparam logic [1:0]  RESP_OKAY     = 2'h0;           // axi okay
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;           // axi slave error for unmapped

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [31:0] data;  // write word
    logic [3:0]  strb;  // byte lanes
  } dept_wdata_t;

  typedef struct packed {
    logic [63:0] set;   // requests to set bits, any number at once
    logic [63:0] clr;   // requests to clear bits
  } dept_setclr_t;

endpackage : dept_pkg

// [rtl/dept_flagword.sv]
// one 64-bit set/clear flag word with set-over-clear priority
// assumes set and clear come from the same clock domain
`timescale 1ns/10ps
module dept_flagword #(
  parameter int WIDTH = 64                     // number of flags
) (
  input  wire logic                clk,        // system clock
  input  wire logic                rst,        // synchronous reset, active high
  input  wire dept_pkg::dept_setclr_t req,     // set and clear requests
  output logic [WIDTH-1:0]         flags_q     // flag state
);

  // ****************************************************************
  // flag update
  // ****************************************************************
  // clear first, then set so a same-cycle set is never lost
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_q <= dept_pkg::FLAGS_RESET[WIDTH-1:0];
    end else begin
      flags_q <= (flags_q & ~req.clr[WIDTH-1:0]) | req.set[WIDTH-1:0];  // [R14]
    end
  end

endmodule // dept_flagword

// [rtl/dept_arbiter.sv]
// picks the lowest-numbered channel with a qualified trigger
// assumes one grant per cycle is enough; grant is registered
`timescale 1ns/10ps
module dept_arbiter #(
  parameter int WIDTH = 64                     // channels
) (
  input  wire logic             clk,           // system clock
  input  wire logic             rst,           // synchronous reset
  input  wire logic [WIDTH-1:0] cand,          // qualified candidates
  output logic                  grant_vld_q,   // a grant was made
  output logic [5:0]            grant_idx_q,   // granted channel
  output logic [WIDTH-1:0]      grant_hot      // one-hot of the grant being made now
);

  logic [5:0]       idx;                       // lowest set index
  logic             any;                       // any candidate

  // ****************************************************************
  // priority encoder
  // ****************************************************************
  always_comb begin
    idx       = 6'h00;
    any       = 1'b0;
    grant_hot = '0;
    for (int i = WIDTH-1; i >= 0; i--) begin
      if (cand[i]) begin
        idx = 6'(i);
        any = 1'b1;
      end
    end
    if (any) begin
      grant_hot[idx] = 1'b1;
    end
  end

  // registered grant report
  always_ff @(posedge clk) begin
    if (rst) begin
      grant_vld_q <= 1'b0;
      grant_idx_q <= 6'h00;
    end else begin
      grant_vld_q <= any;
      grant_idx_q <= idx;
    end
  end

endmodule // dept_arbiter

// [testbench/dept_tracker_properties.sv]
// checker for the event pending tracker: grants, pending flags, bus answers
// assumes it is bound to dept_tracker and sees only its ports
`timescale 1ns/10ps
module dept_tracker_properties (
  input wire logic        REF_CLK,             // system clock
  input wire logic        RESET,               // synchronous reset, active high
  input wire logic        S_AWREADY,           // write address ready
  input wire logic        S_ARVALID,           // read address valid
  input wire logic        S_ARREADY,           // read address ready
  input wire logic        S_BVALID,            // write response valid
  input wire logic        S_BREADY,            // write response ready
  input wire logic [31:0] S_RDATA,             // read data
  input wire logic        S_RVALID,            // read response valid
  input wire logic        S_RREADY,            // read response ready
  input wire logic [63:0] MANUAL_SET_FLAGS,    // manual triggers
  input wire logic [63:0] LATCHED_EVENT_FLAGS, // latched events
  input wire logic [63:0] CHAIN_FLAGS,         // chain triggers
  input wire logic [63:0] HW_DONE,             // hardware clears
  input wire logic        XFER_REQUEST,        // queue pulse
  input wire logic [5:0]  XFER_CHANNEL,        // queued channel
  input wire logic [63:0] QUEUED_FLAGS         // pending flags copy
);
  // ****************************************************************
  // helper logic
  // ****************************************************************
  logic [63:0] trig_q; // any trigger level seen last cycle
  logic [63:0] trig;   // any trigger level now

  assign trig = MANUAL_SET_FLAGS | LATCHED_EVENT_FLAGS | CHAIN_FLAGS;

  // keep last cycle's triggers, a grant must trace back to one
  always_ff @(posedge REF_CLK) begin
    trig_q <= trig;
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  // ****************************************************************
  // assertions
  // ****************************************************************
  grant_sets_flag_a: assert property (
    XFER_REQUEST |=> QUEUED_FLAGS[$past(XFER_CHANNEL)]) else $error("granted channel not flagged");
  grant_not_pending_a: assert property (
    XFER_REQUEST |-> !QUEUED_FLAGS[XFER_CHANNEL]) else $error("pending channel granted again");
  grant_has_cause_a: assert property (
    XFER_REQUEST |-> trig_q[XFER_CHANNEL]) else $error("grant without trigger");
  flag_rise_cause_a: assert property (
    (QUEUED_FLAGS & ~$past(QUEUED_FLAGS)) != 64'h0 |-> $past(XFER_REQUEST)
      && ((QUEUED_FLAGS & ~$past(QUEUED_FLAGS)) == (64'h1 << $past(XFER_CHANNEL))))
    else $error("pending flag rose without grant");
  hw_clear_a: assert property (
    (HW_DONE != 64'h0 && trig == 64'h0) |=> ##1 (QUEUED_FLAGS & $past(HW_DONE, 2)) == 64'h0)
    else $error("hardware clear lost");
  reset_clears_a: assert property (disable iff (1'b0)
    RESET |=> QUEUED_FLAGS == 64'h0 && !XFER_REQUEST) else $error("outputs not cleared by reset");
  ready_after_reset_a: assert property (
    $fell(RESET) |-> !S_AWREADY && !S_ARREADY) else $error("ready too soon after reset");
  read_answer_a: assert property (
    S_ARVALID && S_ARREADY |=> S_RVALID) else $error("read answer late");
  rdata_hold_a: assert property (
    S_RVALID && !S_RREADY |=> S_RVALID && $stable(S_RDATA)) else $error("read answer dropped");
  bresp_hold_a: assert property (
    S_BVALID && !S_BREADY |=> S_BVALID) else $error("write answer dropped");

  // main scenarios reached
  grant_c: cover property (XFER_REQUEST);
  hw_clear_c: cover property (HW_DONE != 64'h0);
  write_c: cover property (S_BVALID && S_BREADY);
endmodule // dept_tracker_properties

// [testbench/dept_tracker_tb.sv]
// self-checking bench for the event pending tracker over its axi4-lite port
// assumes the design answers within a few cycles; all waits are bounded
`timescale 1ns/10ps
module dept_tracker_tb;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        clk = 1'b0, rst = 1'b1;           // clock and reset
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;   // bus addresses
  logic        awvalid = 1'b0, wvalid = 1'b0;    // write requests
  logic        bready = 1'b0, arvalid = 1'b0;    // response ready, read request
  logic        rready = 1'b0;                    // read ready
  logic [31:0] wdata = 32'h0;                    // write word
  logic [63:0] manual = '0, latched = '0;        // trigger levels
  logic [63:0] chain = '0, hw_done = '0;         // chain levels, hardware clears
  wire         awready, wready, bvalid, arready, rvalid, xfer; // design handshakes
  wire  [1:0]  bresp, rresp;                     // responses
  wire  [31:0] rdata;                            // read word
  wire  [5:0]  xch;                              // granted channel
  wire  [63:0] queued;                           // pending copy
  logic [5:0]  got[$];                           // grants seen
  int          n_fail = 0, num_checks = 0;       // counters

  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  dept_tracker DUT (.REF_CLK(clk), .RESET(rst), .S_AWADDR(awaddr), .S_AWVALID(awvalid), .S_AWREADY(awready),
    .S_WDATA(wdata), .S_WSTRB(4'hF), .S_WVALID(wvalid), .S_WREADY(wready), .S_BRESP(bresp), .S_BVALID(bvalid),
    .S_BREADY(bready), .S_ARADDR(araddr), .S_ARVALID(arvalid), .S_ARREADY(arready), .S_RDATA(rdata),
    .S_RRESP(rresp), .S_RVALID(rvalid), .S_RREADY(rready), .MANUAL_SET_FLAGS(manual),
    .LATCHED_EVENT_FLAGS(latched), .CHAIN_FLAGS(chain), .HW_DONE(hw_done), .XFER_REQUEST(xfer),
    .XFER_CHANNEL(xch), .QUEUED_FLAGS(queued));

  // record every grant, scenarios judge the list
  always @(posedge clk) begin
    if (xfer === 1'b1) got.push_back(xch);
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (i == 100) chk(64'h1, 64'h0); // hung write
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (i == 100) chk(64'h1, 64'h0); // hung read
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(64'(d), 64'(exp));
  endtask

  // hold trigger levels for n+1 cycles, hardware clear for the first only
  task automatic drive(input logic [63:0] m, c, l, h, input int n);
    @(posedge clk);
    manual <= m; chain <= c; latched <= l; hw_done <= h;
    @(posedge clk);
    hw_done <= '0;
    repeat (n) @(posedge clk);
    manual <= '0; chain <= '0; latched <= '0;
    repeat (3) @(posedge clk);
  endtask

  // compare grant list with up to two channels, then empty it
  task automatic grants(input int n, input logic [5:0] a, b);
    chk(64'(got.size()), 64'(n));
    if (n > 0 && got.size() > 0) chk(64'(got[0]), 64'(a));
    if (n > 1 && got.size() > 1) chk(64'(got[1]), 64'(b));
    got.delete();
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic s_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk(dept_pkg::OFF_QUEUED_LOW, 32'h0);
    rd_chk(dept_pkg::OFF_QUEUED_HIGH, 32'h0);
    rd_chk(dept_pkg::OFF_ENABLE_SET_HIGH, 32'h0);
    rd_chk(dept_pkg::OFF_QUEUED_CLR_LOW, 32'h0);
    rd(8'h40, d, r);
    chk(64'(r), 64'(dept_pkg::RESP_SLVERR));
  endtask

  task automatic s_enable;
    logic [1:0] r;
    wr(dept_pkg::OFF_ENABLE_SET_HIGH, 32'h8000_0001, r);
    rd_chk(dept_pkg::OFF_ENABLE_MASK_HIGH, 32'h8000_0001);
    wr(dept_pkg::OFF_ENABLE_SET_HIGH, 32'h0000_0002, r);
    rd_chk(dept_pkg::OFF_ENABLE_MASK_HIGH, 32'h8000_0003);
    wr(dept_pkg::OFF_ENABLE_MASK_HIGH, 32'h0000_0000, r);
    rd_chk(dept_pkg::OFF_ENABLE_MASK_HIGH, 32'h8000_0003);
    rd_chk(dept_pkg::OFF_ENABLE_MASK_LOW, 32'h0);
  endtask

  task automatic s_latched;
    logic [1:0] r;
    drive('0, '0, 64'h0000_0004_0000_0000, '0, 4);
    grants(0, 6'h00, 6'h00);
    drive('0, '0, 64'h8000_0001_0000_0000, '0, 4);
    grants(2, 6'h20, 6'h3F);
    rd_chk(dept_pkg::OFF_QUEUED_HIGH, 32'h8000_0001);
    drive('0, '0, '0, 64'h0000_0001_0000_0000, 0);
    rd_chk(dept_pkg::OFF_QUEUED_HIGH, 32'h8000_0000);
    wr(dept_pkg::OFF_QUEUED_CLR_HIGH, 32'h8000_0000, r);
    rd_chk(dept_pkg::OFF_QUEUED_HIGH, 32'h0);
  endtask

  task automatic s_low_clear;
    logic [1:0] r;
    drive(64'h21, '0, '0, '0, 4);
    grants(2, 6'h00, 6'h05);
    wr(dept_pkg::OFF_QUEUED_LOW, 32'hFFFF_FFFF, r);
    chk(64'(r), 64'(dept_pkg::RESP_OKAY));
    rd_chk(dept_pkg::OFF_QUEUED_LOW, 32'h21);
    wr(dept_pkg::OFF_QUEUED_CLR_LOW, 32'h1, r);
    rd_chk(dept_pkg::OFF_QUEUED_LOW, 32'h20);
    wr(dept_pkg::OFF_QUEUED_CLR_LOW, 32'h20, r);
    rd_chk(dept_pkg::OFF_QUEUED_LOW, 32'h0);
    drive('0, 64'h0000_0100_0000_0000, '0, '0, 2);
    grants(1, 6'h28, 6'h00);
    rd_chk(dept_pkg::OFF_QUEUED_HIGH, 32'h100);
    wr(dept_pkg::OFF_QUEUED_CLR_HIGH, 32'h100, r);
    rd_chk(dept_pkg::OFF_QUEUED_HIGH, 32'h0);
  endtask

  task automatic s_set_wins;
    drive(64'h80, '0, '0, 64'h80, 3);
    grants(1, 6'h07, 6'h00);
    rd_chk(dept_pkg::OFF_QUEUED_LOW, 32'h80);
    chk(queued, 64'h80);
  endtask

  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    s_reset();
    s_enable();
    s_latched();
    s_low_clear();
    s_set_wins();
    tally_and_finish();
  end

  // watchdog, far past the scenarios' length
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
endmodule // dept_tracker_tb

bind dept_tracker dept_tracker_properties u_props (.REF_CLK(REF_CLK), .RESET(RESET), .S_AWREADY(S_AWREADY),
  .S_ARVALID(S_ARVALID), .S_ARREADY(S_ARREADY), .S_BVALID(S_BVALID), .S_BREADY(S_BREADY), .S_RDATA(S_RDATA),
  .S_RVALID(S_RVALID), .S_RREADY(S_RREADY), .MANUAL_SET_FLAGS(MANUAL_SET_FLAGS),
  .LATCHED_EVENT_FLAGS(LATCHED_EVENT_FLAGS), .CHAIN_FLAGS(CHAIN_FLAGS), .HW_DONE(HW_DONE),
  .XFER_REQUEST(XFER_REQUEST), .XFER_CHANNEL(XFER_CHANNEL), .QUEUED_FLAGS(QUEUED_FLAGS));
